// ===== rtl/msi_cap_bank.sv
// Interrupt-message, vendor capability and link timer register bank behind AXI4-Lite
`timescale 1ns/10ps
`include "msi_cap_regs.svh"

module msi_cap_bank
    import msi_cap_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [11:0] REPLAY_BUILTIN = 12'h100,
    parameter logic [13:0] ACK_BUILTIN = 14'h0040
) (
    input wire logic clk, // Core clock
    input wire logic rst, // Async reset, active high
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic load_valid, // Autoload strobe for the timer word
    input wire logic [31:0] load_word, // Autoload value in timer word layout
    input wire logic legacy_int_req, // Interrupt request from the port
    input wire logic msi_event, // Pulse: port wants a message interrupt
    output logic intx_assert, // Legacy interrupt line drive
    output logic msi_wr_valid, // Pulse: issue interrupt memory write
    output logic [63:0] msi_wr_addr, // Target address of that write
    output logic [15:0] msi_wr_data, // Payload of that write
    output logic [2:0] msi_mm_enable, // Granted message count code
    output logic [11:0] replay_timeout, // Replay time-out in use
    output logic [13:0] ack_latency, // Ack latency in use
    output logic vga_decode_en, // VGA range decode enable
    output logic pm_cap_present, // Power management cap in chain
    output logic msi_cap_present // Interrupt-message cap in chain
);
    state_t s_r;
    state_t s_nxt;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_go;
    logic msi_live;

    // Decode reads bits 7:0 of the address, so narrower buses cannot be served
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 8 and 32");
    end

    // Byte strobes widened to a bit mask
    generate
        for (genvar i = 0; i < 4; i++) begin : g_mask
            assign wmask[i*8 +: 8] = {8{s_r.w_strb[i]}};
        end
    endgenerate

    // Read view of one word; unmapped words read zero with an error
    function automatic logic [32:0] read_word(input logic [7:0] a, input state_t s);
        logic [32:0] r;
        r = {1'b1, 32'h00000000};
        unique case (a)
            `OFF_MSI_CTRL: r[31:0] = {8'h00, `MSI_64BIT_CAP, s.mm_en, `MSI_MM_CAPABLE,
                s.msi_en, `MSI_NEXT_PTR, `MSI_CAP_ID};
            `OFF_MSG_ADDR_LO: r[31:0] = {s.addr_lo, 2'b00};
            `OFF_MSG_ADDR_HI: r[31:0] = s.addr_hi;
            `OFF_MSG_PAYLOAD: r[31:0] = {16'h0000, s.payload};
            `OFF_VENDOR_CAP: r[31:0] = {`VEN_LENGTH, `VEN_NEXT_PTR, `VEN_CAP_ID};
            `OFF_TEST_WORD0: r[31:0] = s.test0;
            `OFF_TEST_WORD1: r[31:0] = s.test1;
            `OFF_TIMER_CTRL: r[31:0] = {`VGA_DECODE_RST, s.ack_en, s.ack_val, 1'b0,
                s.msi_dis, s.pm_dis, s.replay_en, s.replay_val};
            default: r[32] = 1'b0;
        endcase
        return r;
    endfunction

    always_comb begin
        logic [32:0] rw;
        logic [31:0] old;
        logic [31:0] nw;
        old = 32'h00000000;
        nw = 32'h00000000;
        rw = read_word(s_axi_araddr[7:0], s_r);
        rd_word = rw[31:0];
        rd_hit = rw[32];
        wr_go = s_r.aw_have && s_r.w_have && !s_r.bvalid;
        msi_live = s_r.msi_en && !s_r.msi_dis;
        s_nxt = s_r;

        // Write channels are captured independently, in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Autoload of timer defaults; a software write in the same cycle wins for replay and ack fields, not pm_dis or msi_dis
        if (load_valid) begin
            s_nxt.replay_val = load_word[11:0];
            s_nxt.replay_en = load_word[`BIT_REPLAY_EN];
            s_nxt.pm_dis = load_word[`BIT_PM_DIS];
            s_nxt.msi_dis = load_word[`BIT_MSI_DIS];
            s_nxt.ack_val = load_word[`POS_ACK_VAL +: 14];
            s_nxt.ack_en = load_word[`BIT_ACK_EN];
        end

        if (wr_go) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `RESP_OKAY;
            rw = read_word(s_r.aw_addr, s_r);
            old = rw[31:0];
            nw = (old & ~wmask) | (s_r.w_data & wmask);
            if (!rw[32]) begin
                s_nxt.bresp = `RESP_DECERR;
            end
            unique case (s_r.aw_addr)
                `OFF_MSI_CTRL: begin
                    s_nxt.msi_en = nw[`BIT_MSI_EN];
                    s_nxt.mm_en = nw[`POS_MM_EN +: 3];
                end
                `OFF_MSG_ADDR_LO: s_nxt.addr_lo = nw[31:2];
                `OFF_MSG_ADDR_HI: s_nxt.addr_hi = nw;
                `OFF_MSG_PAYLOAD: s_nxt.payload = nw[15:0];
                `OFF_TEST_WORD0: s_nxt.test0 = nw;
                `OFF_TEST_WORD1: s_nxt.test1 = nw;
                `OFF_TIMER_CTRL: begin
                    s_nxt.replay_val = nw[11:0];
                    s_nxt.replay_en = nw[`BIT_REPLAY_EN];
                    s_nxt.ack_val = nw[`POS_ACK_VAL +: 14];
                    s_nxt.ack_en = nw[`BIT_ACK_EN];
                end
                // Read-only words accept the write and keep their value
                default: s_nxt.bresp = rw[32] ? `RESP_OKAY : `RESP_DECERR;
            endcase
        end
        s_nxt.awready = !s_nxt.aw_have;
        s_nxt.wready = !s_nxt.w_have;

        // Read: one word in flight; address taken, data valid next cycle
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_word;
            s_nxt.rresp = rd_hit ? `RESP_OKAY : `RESP_DECERR;
        end

        // Interrupt delivery: message when msi_en is set and msi_dis clear, legacy line otherwise
        s_nxt.intx = legacy_int_req && !msi_live;
        s_nxt.msi_wv = msi_event && msi_live;
        if (msi_event && msi_live) begin
            s_nxt.msi_wa = {s_r.addr_hi, s_r.addr_lo, 2'b00};
            s_nxt.msi_wd = s_r.payload;
        end

        s_nxt.replay_eff = s_r.replay_en ? s_r.replay_val : REPLAY_BUILTIN;
        s_nxt.ack_eff = s_r.ack_en ? s_r.ack_val : ACK_BUILTIN;
        s_nxt.pm_present = !s_r.pm_dis;
        s_nxt.msi_present = !s_r.msi_dis;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.test0 <= `TEST_WORD0_RST;
            s_r.test1 <= `TEST_WORD1_RST;
            s_r.replay_eff <= REPLAY_BUILTIN;
            s_r.ack_eff <= ACK_BUILTIN;
            s_r.pm_present <= 1'b1;
            s_r.msi_present <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign intx_assert = s_r.intx;
    assign msi_wr_valid = s_r.msi_wv;
    assign msi_wr_addr = s_r.msi_wa;
    assign msi_wr_data = s_r.msi_wd;
    assign msi_mm_enable = s_r.mm_en;
    assign replay_timeout = s_r.replay_eff;
    assign ack_latency = s_r.ack_eff;
    assign vga_decode_en = `VGA_DECODE_RST;
    assign pm_cap_present = s_r.pm_present;
    assign msi_cap_present = s_r.msi_present;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic ar_take;
    logic wr_full;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign wr_full = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && (s_axi_wstrb == 4'hF) && !s_axi_bvalid && !load_valid;

    property p_msi_hdr;
        ar_take && s_axi_araddr[7:0] == `OFF_MSI_CTRL
            |=> s_axi_rvalid && s_axi_rdata[7:0] == 8'h05;
    endproperty
    a_msi_hdr: assert property (p_msi_hdr) else $error("bad interrupt cap id");

    property p_msi_next;
        ar_take && s_axi_araddr[7:0] == `OFF_MSI_CTRL
            |=> s_axi_rdata[15:8] == 8'h64 && s_axi_rdata[23];
    endproperty
    a_msi_next: assert property (p_msi_next) else $error("bad pointer or 64-bit bit");

    property p_msg_gate;
        msi_wr_valid |-> $past(s_r.msi_en) && !intx_assert;
    endproperty
    a_msg_gate: assert property (p_msg_gate) else $error("message while disabled");

    property p_intx_block;
        legacy_int_req && s_r.msi_en && !s_r.msi_dis |=> !intx_assert;
    endproperty
    a_intx_block: assert property (p_intx_block) else $error("legacy line while enabled");

    property p_addr_low;
        ar_take && s_axi_araddr[7:0] == `OFF_MSG_ADDR_LO |=> s_axi_rdata[1:0] == 2'b00;
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("address low bits set");

    property p_msg_out;
        msi_event && s_r.msi_en && !s_r.msi_dis
            |=> msi_wr_valid && msi_wr_data == $past(s_r.payload)
                && msi_wr_addr == {$past(s_r.addr_hi), $past(s_r.addr_lo), 2'b00};
    endproperty
    a_msg_out: assert property (p_msg_out) else $error("wrong message write");

    property p_vendor;
        ar_take && s_axi_araddr[7:0] == `OFF_VENDOR_CAP |=> s_axi_rdata == 32'h0034B009;
    endproperty
    a_vendor: assert property (p_vendor) else $error("bad vendor header");

    property p_test0_wr;
        wr_full && s_axi_awaddr[7:0] == `OFF_TEST_WORD0
            |=> ##1 s_r.test0 == $past(s_axi_wdata, 2);
    endproperty
    a_test0_wr: assert property (p_test0_wr) else $error("test word 0 not written");

    property p_replay_sel;
        s_r.replay_en ##1 s_r.replay_en && $stable(s_r.replay_val)
            |-> replay_timeout == s_r.replay_val;
    endproperty
    a_replay_sel: assert property (p_replay_sel) else $error("replay value not used");

    property p_ack_sel;
        !s_r.ack_en [*2] |-> ack_latency == ACK_BUILTIN;
    endproperty
    a_ack_sel: assert property (p_ack_sel) else $error("ack built-in not used");

    property p_vga;
        ar_take && s_axi_araddr[7:0] == `OFF_TIMER_CTRL |=> s_axi_rdata[31] && vga_decode_en;
    endproperty
    a_vga: assert property (p_vga) else $error("VGA bit not one");

    property p_autoload;
        load_valid && !(s_r.aw_have && s_r.w_have && !s_r.bvalid)
            |=> s_r.replay_val == $past(load_word[11:0])
                && s_r.ack_val == $past(load_word[29:16]);
    endproperty
    a_autoload: assert property (p_autoload) else $error("autoload lost");

    property p_cap_drop;
        s_r.msi_dis [*2] |-> !msi_cap_present;
    endproperty
    a_cap_drop: assert property (p_cap_drop) else $error("disabled cap still present");

    property p_msi_off;
        !s_r.msi_en |=> !msi_wr_valid;
    endproperty
    a_msi_off: assert property (p_msi_off) else $error("message while enable clear");

    property p_vendor_id;
        ar_take && s_axi_araddr[7:0] == `OFF_VENDOR_CAP |=> s_axi_rdata[7:0] == 8'h09;
    endproperty
    a_vendor_id: assert property (p_vendor_id) else $error("bad vendor cap id");

    property p_vendor_next;
        ar_take && s_axi_araddr[7:0] == `OFF_VENDOR_CAP |=> s_axi_rdata[15:8] == 8'hB0;
    endproperty
    a_vendor_next: assert property (p_vendor_next) else $error("bad vendor pointer");

    property p_upper_wr;
        wr_full && s_axi_awaddr[7:0] == `OFF_MSG_ADDR_HI
            |=> ##1 s_r.addr_hi == $past(s_axi_wdata, 2);
    endproperty
    a_upper_wr: assert property (p_upper_wr) else $error("upper address not written");

    property p_test1_wr;
        wr_full && s_axi_awaddr[7:0] == `OFF_TEST_WORD1
            |=> ##1 s_r.test1 == $past(s_axi_wdata, 2);
    endproperty
    a_test1_wr: assert property (p_test1_wr) else $error("test word 1 not written");

    property p_replay_wr;
        wr_full && s_axi_awaddr[7:0] == `OFF_TIMER_CTRL
            |=> ##1 s_r.replay_val == $past(s_axi_wdata[11:0], 2);
    endproperty
    a_replay_wr: assert property (p_replay_wr) else $error("replay value not written");

    property p_ack_wr;
        wr_full && s_axi_awaddr[7:0] == `OFF_TIMER_CTRL
            |=> ##1 s_r.ack_val == $past(s_axi_wdata[29:16], 2);
    endproperty
    a_ack_wr: assert property (p_ack_wr) else $error("ack value not written");

    property p_cv_msg;
        msi_wr_valid;
    endproperty
    c_cv_msg: cover property (p_cv_msg);

    property p_cv_write;
        s_axi_bvalid && s_axi_bready && s_axi_bresp == `RESP_OKAY;
    endproperty
    c_cv_write: cover property (p_cv_write);

    property p_cv_user;
        s_r.replay_en && s_r.ack_en;
    endproperty
    c_cv_user: cover property (p_cv_user);

    property p_cv_read;
        s_axi_rvalid && s_axi_rready && s_axi_rresp == `RESP_DECERR;
    endproperty
    c_cv_read: cover property (p_cv_read);
endmodule

// ===== rtl/msi_cap_pkg.sv
// Types of the capability register bank
package msi_cap_pkg;
    typedef struct packed {
        logic awready;
        logic aw_have;
        logic [7:0] aw_addr;
        logic wready;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic msi_en;
        logic [2:0] mm_en;
        logic [29:0] addr_lo;
        logic [31:0] addr_hi;
        logic [15:0] payload;
        logic [31:0] test0;
        logic [31:0] test1;
        logic [11:0] replay_val;
        logic replay_en;
        logic pm_dis;
        logic msi_dis;
        logic [13:0] ack_val;
        logic ack_en;
        logic intx;
        logic msi_wv;
        logic [63:0] msi_wa;
        logic [15:0] msi_wd;
        logic [11:0] replay_eff;
        logic [13:0] ack_eff;
        logic pm_present;
        logic msi_present;
    } state_t;
endpackage

// ===== rtl/msi_cap_regs.svh
// Register offsets, field positions, reset values and fixed codes of the capability bank
`ifndef MSI_CAP_REGS_SVH
`define MSI_CAP_REGS_SVH
`define OFF_MSI_CTRL 8'h4C
`define OFF_MSG_ADDR_LO 8'h50
`define OFF_MSG_ADDR_HI 8'h54
`define OFF_MSG_PAYLOAD 8'h58
`define OFF_VENDOR_CAP 8'h64
`define OFF_TEST_WORD0 8'h68
`define OFF_TEST_WORD1 8'h6C
`define OFF_TIMER_CTRL 8'h70
`define MSI_CAP_ID 8'h05
`define MSI_NEXT_PTR 8'h64
`define MSI_MM_CAPABLE 3'h2
`define MSI_64BIT_CAP 1'h1
`define VEN_CAP_ID 8'h09
`define VEN_NEXT_PTR 8'hB0
`define VEN_LENGTH 16'h0034
`define TEST_WORD0_RST 32'h04001060
`define TEST_WORD1_RST 32'h00000800
`define VGA_DECODE_RST 1'h1
`define BIT_MSI_EN 16
`define POS_MM_EN 20
`define BIT_64BIT 23
`define BIT_REPLAY_EN 12
`define BIT_PM_DIS 13
`define BIT_MSI_DIS 14
`define POS_ACK_VAL 16
`define BIT_ACK_EN 30
`define BIT_VGA 31
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define LAT_WRITE_CYC 1
`define LAT_READ_CYC 1
`endif

// ===== testbench/tb_msi_cap_bank.sv
// Self-checking testbench of the capability register bank
`timescale 1ns/10ps
`include "msi_cap_regs.svh"

module tb_msi_cap_bank;
    localparam logic [11:0] REPLAY_B = 12'h100;
    localparam logic [13:0] ACK_B = 14'h0040;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, load_valid, legacy_int_req, msi_event;
    logic intx_assert, msi_wr_valid, vga_decode_en, pm_cap_present, msi_cap_present;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, load_word, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [63:0] msi_wr_addr;
    logic [15:0] msi_wr_data;
    logic [2:0] msi_mm_enable;
    logic [11:0] replay_timeout;
    logic [13:0] ack_latency;
    int mismatches = 0;
    int checks = 0;

    msi_cap_bank #(.ADDR_W(8), .REPLAY_BUILTIN(REPLAY_B), .ACK_BUILTIN(ACK_B)) DUT (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .load_valid(load_valid), .load_word(load_word), .legacy_int_req(legacy_int_req),
        .msi_event(msi_event), .intx_assert(intx_assert), .msi_wr_valid(msi_wr_valid),
        .msi_wr_addr(msi_wr_addr), .msi_wr_data(msi_wr_data),
        .msi_mm_enable(msi_mm_enable), .replay_timeout(replay_timeout),
        .ack_latency(ack_latency), .vga_decode_en(vga_decode_en),
        .pm_cap_present(pm_cap_present), .msi_cap_present(msi_cap_present));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic timed_out(input logic done);
        if (!done) begin
            $display("ERROR bus wait expected answer seen none");
            mismatches++;
            stop_test();
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        timed_out(done);
    endtask

    task automatic axi_read(input logic [7:0] a);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && n < 100) begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        timed_out(done);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] r);
        axi_read(a);
        check($sformatf("read %h", a), {32'h0, exp}, {32'h0, rd});
        check($sformatf("rresp %h", a), {62'h0, r}, {62'h0, rs});
    endtask

    task automatic pulse_msi(input logic exp);
        @(posedge clk);
        msi_event <= 1'b1;
        @(posedge clk);
        msi_event <= 1'b0;
        #1;
        check("msi_wr_valid", {63'h0, exp}, {63'h0, msi_wr_valid});
        @(posedge clk);
        #1;
        check("msi_wr_valid drop", 64'h0, {63'h0, msi_wr_valid});
    endtask

    task automatic t_reset();
        rd_check(`OFF_MSI_CTRL, 32'h00846405, 2'h0);
        rd_check(`OFF_MSG_ADDR_LO, 32'h00000000, 2'h0);
        rd_check(`OFF_MSG_ADDR_HI, 32'h00000000, 2'h0);
        rd_check(`OFF_MSG_PAYLOAD, 32'h00000000, 2'h0);
        rd_check(`OFF_VENDOR_CAP, 32'h0034B009, 2'h0);
        rd_check(`OFF_TEST_WORD0, 32'h04001060, 2'h0);
        rd_check(`OFF_TEST_WORD1, 32'h00000800, 2'h0);
        rd_check(`OFF_TIMER_CTRL, 32'h80000000, 2'h0);
        check("replay", {52'h0, REPLAY_B}, {52'h0, replay_timeout});
        check("ack", {50'h0, ACK_B}, {50'h0, ack_latency});
        check("vga", 64'h1, {63'h0, vga_decode_en});
        check("caps", 64'h3, {62'h0, pm_cap_present, msi_cap_present});
        $display("Test reset values done");
    endtask

    task automatic t_all_ones();
        logic [7:0] offs [8];
        logic [31:0] exps [8];
        offs = '{8'h4C, 8'h50, 8'h54, 8'h58, 8'h64, 8'h68, 8'h6C, 8'h70};
        exps = '{32'h00F56405, 32'hFFFFFFFC, 32'hFFFFFFFF, 32'h0000FFFF, 32'h0034B009,
                 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFF1FFF};
        foreach (offs[i]) begin
            axi_write(offs[i], 32'hFFFFFFFF, 4'hF);
            check("bresp", 64'h0, {62'h0, rs});
            rd_check(offs[i], exps[i], 2'h0);
        end
        check("replay user", 64'hFFF, {52'h0, replay_timeout});
        check("ack user", 64'h3FFF, {50'h0, ack_latency});
        check("mm enable", 64'h7, {61'h0, msi_mm_enable});
        axi_write(`OFF_TEST_WORD1, 32'h00000000, 4'hF);
        axi_write(`OFF_TEST_WORD1, 32'hFFFFFFFF, 4'h1);
        rd_check(`OFF_TEST_WORD1, 32'h000000FF, 2'h0);
        axi_write(8'h60, 32'h12345678, 4'hF);
        check("unmapped bresp", 64'h3, {62'h0, rs});
        rd_check(8'h60, 32'h00000000, 2'h3);
        $display("Test write and read back done");
    endtask

    task automatic t_msi();
        axi_write(`OFF_MSI_CTRL, 32'h00000000, 4'hF);
        legacy_int_req <= 1'b1;
        pulse_msi(1'b0);
        check("intx legacy", 64'h1, {63'h0, intx_assert});
        axi_write(`OFF_MSG_ADDR_LO, 32'h12345677, 4'hF);
        axi_write(`OFF_MSG_ADDR_HI, 32'hA5A50001, 4'hF);
        axi_write(`OFF_MSG_PAYLOAD, 32'hFFFFBEEF, 4'hF);
        axi_write(`OFF_MSI_CTRL, 32'h00010000, 4'hF);
        pulse_msi(1'b1);
        check("msi addr", 64'hA5A5000112345674, msi_wr_addr);
        check("msi data", 64'hBEEF, {48'h0, msi_wr_data});
        check("intx off", 64'h0, {63'h0, intx_assert});
        $display("Test interrupt messages done");
    endtask

    task automatic t_autoload();
        @(posedge clk);
        load_valid <= 1'b1;
        load_word <= 32'h4ABC6123;
        @(posedge clk);
        load_valid <= 1'b0;
        @(posedge clk);
        #1;
        check("replay builtin", {52'h0, REPLAY_B}, {52'h0, replay_timeout});
        check("ack load", 64'h0ABC, {50'h0, ack_latency});
        check("caps off", 64'h0, {62'h0, pm_cap_present, msi_cap_present});
        rd_check(`OFF_TIMER_CTRL, 32'hCABC6123, 2'h0);
        axi_write(`OFF_TIMER_CTRL, 32'h00000000, 4'hF);
        rd_check(`OFF_TIMER_CTRL, 32'h80006000, 2'h0);
        pulse_msi(1'b0);
        check("intx disabled cap", 64'h1, {63'h0, intx_assert});
        $display("Test autoload done");
    endtask

    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {load_valid, legacy_int_req, msi_event} = 3'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        load_word = 32'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_all_ones();
        t_msi();
        t_autoload();
        stop_test();
    end
endmodule
